/* hw/ffam_core.sv */
// Fault flags, clear rules, alert mask and active-low alert output
// Overview of operation
// - Overcurrent flag bit 3 follows output demand above about 50 mA.
// - Automatic clear mode: overcurrent flag clears once the condition is gone.
// - Host clear mode: overcurrent flag holds until status read.
// - Bad output or input-pair codes rejected, old kept, config flag set.
// - DAC mode with buffers off powers them up and sets config flag.
// - Mux on powered-down buffer holds config flag while it persists.
// - Checksum flag bit 1 sets on CRC mismatch only when enabled.
// - Edge flag bit 0 sets on GPI edge, cleared by read.
// - Mask bits 3:0 each gate their own flag; writable bits 8:6 and 4 gate nothing; reset value zero.
`timescale 1ns/1ps
`default_nettype none
`include "ffam_params.svh"

module ffam_core (
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   input  wire ffam_pkg::ffam_addr_t reg_addr,
   input  wire ffam_pkg::ffam_word_t reg_wdata,
   output logic [23:0]            reg_rdata,
   input  wire logic              overcurrent_pin,
   input  wire logic              crc_mismatch,
   input  wire logic [5:0]        gpi_edge,
   output logic [5:0]             buffer_power,
   output logic [3:0]             output_mode_code,
   output logic                   alert_n
);
   import ffam_pkg::*;

   // ----------------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------------
   ffam_core_s st_ff;
   ffam_core_s nxt_st;
   ffam_cfg_if cfg_bus ();

   logic       rd_status;
   logic [3:0] status_now;

   ffam_cfg u_cfg (
      .clk   (clk),
      .reset (reset),
      .cfg   (cfg_bus.cfg)
   );

   assign cfg_bus.wr_gen  = reg_wr && (reg_addr == `FFAM_ADDR_GEN_CFG);
   assign cfg_bus.wr_mode = reg_wr && (reg_addr == `FFAM_ADDR_MODE_CFG);
   assign cfg_bus.wdata   = reg_wdata;

   assign rd_status = reg_rd && (reg_addr == `FFAM_ADDR_STATUS);

   // ----------------------------------------------------------------------------
   // Status as seen by a read
   // ----------------------------------------------------------------------------
   always_comb begin
      status_now                 = 4'h0;
      status_now[`FFAM_BIT_OVC]  = st_ff.ovc_flag;
      status_now[`FFAM_BIT_CFG]  = st_ff.cfg_sticky | cfg_bus.mux_bad;
      status_now[`FFAM_BIT_CRC]  = st_ff.crc_flag;
      status_now[`FFAM_BIT_EDGE] = st_ff.edge_flag;
   end

   // ----------------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------------
   always_comb begin
      logic [3:0] nxt_status;
      nxt_status = 4'h0;
      nxt_st     = st_ff;

      // Pin is asynchronous to clk
      nxt_st.ovc_meta = overcurrent_pin;
      nxt_st.ovc_sync = st_ff.ovc_meta;

      if (cfg_bus.ovc_mode) begin
         nxt_st.ovc_flag = st_ff.ovc_sync | (st_ff.ovc_flag & ~rd_status);
      end else begin
         nxt_st.ovc_flag = st_ff.ovc_sync;
      end

      nxt_st.cfg_sticky = cfg_bus.err_evt | (st_ff.cfg_sticky & ~rd_status);

      nxt_st.crc_flag = (crc_mismatch & cfg_bus.crc_en) | (st_ff.crc_flag & ~rd_status);

      nxt_st.edge_flag = (|gpi_edge) | (st_ff.edge_flag & ~rd_status);

      if (reg_wr && (reg_addr == `FFAM_ADDR_MASK)) begin
         nxt_st.mask = reg_wdata & `FFAM_MASK_WMASK;
      end

      // Read data captures flags before the clear lands
      nxt_st.rdata = '0;
      if (reg_rd) begin
         unique case (reg_addr)
            `FFAM_ADDR_STATUS: begin
               nxt_st.rdata[3:0] = status_now;
            end
            `FFAM_ADDR_MASK: begin
               nxt_st.rdata = st_ff.mask;
            end
            `FFAM_ADDR_GEN_CFG: begin
               nxt_st.rdata[`FFAM_GEN_BUF_LSB +: 6] = cfg_bus.buf_on;
               nxt_st.rdata[`FFAM_GEN_OVC_MODE]     = cfg_bus.ovc_mode;
               nxt_st.rdata[`FFAM_GEN_CRC_EN]       = cfg_bus.crc_en;
            end
            `FFAM_ADDR_MODE_CFG: begin
               nxt_st.rdata[`FFAM_MODE_OUT_LSB +: 4] = cfg_bus.out_mode;
               nxt_st.rdata[`FFAM_MODE_PA_LSB +: 4]  = cfg_bus.pair_a;
               nxt_st.rdata[`FFAM_MODE_PC_LSB +: 4]  = cfg_bus.pair_c;
               nxt_st.rdata[`FFAM_MODE_MUX_LSB +: 3] = cfg_bus.mux_sel;
            end
            default: begin
               nxt_st.rdata = '0;
            end
         endcase
      end

      // Alert tracks next flag values so it changes with the flags
      nxt_status[`FFAM_BIT_OVC]  = nxt_st.ovc_flag;
      nxt_status[`FFAM_BIT_CFG]  = nxt_st.cfg_sticky | cfg_bus.mux_bad;
      nxt_status[`FFAM_BIT_CRC]  = nxt_st.crc_flag;
      nxt_status[`FFAM_BIT_EDGE] = nxt_st.edge_flag;
      nxt_st.alert_n = ~|(nxt_status & nxt_st.mask[3:0]);
   end

   // ----------------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         st_ff          <= '0;
         st_ff.mask     <= `FFAM_MASK_RESET;
         st_ff.alert_n  <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign reg_rdata        = st_ff.rdata;
   assign alert_n          = st_ff.alert_n;
   assign buffer_power     = cfg_bus.buf_on;
   assign output_mode_code = cfg_bus.out_mode;

endmodule : ffam_core

`default_nettype wire

/* hw/ffam_params.svh */
// Offsets, field positions, reset values and masks of the fault flag block
`ifndef FFAM_PARAMS_SVH
`define FFAM_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define FFAM_ADDR_GEN_CFG    8'h01
`define FFAM_ADDR_MODE_CFG   8'h02
`define FFAM_ADDR_STATUS     8'h07
`define FFAM_ADDR_MASK       8'h08

// ----------------------------------------------------------------------------
// Status and mask bit positions
// ----------------------------------------------------------------------------
`define FFAM_BIT_EDGE        0
`define FFAM_BIT_CRC         1
`define FFAM_BIT_CFG         2
`define FFAM_BIT_OVC         3

// ----------------------------------------------------------------------------
// Alert mask: writable bits 8,7,6,4,3,2,1,0; bit 5 and 23:9 reserved
// ----------------------------------------------------------------------------
`define FFAM_MASK_WMASK      24'h0001DF
`define FFAM_MASK_RESET      24'h000000

// ----------------------------------------------------------------------------
// General config fields
// ----------------------------------------------------------------------------
`define FFAM_GEN_BUF_LSB     0
`define FFAM_GEN_OVC_MODE    6
`define FFAM_GEN_CRC_EN      7
`define FFAM_GEN_RESET       8'h00

// ----------------------------------------------------------------------------
// Mode config fields and legal code limits
// ----------------------------------------------------------------------------
`define FFAM_MODE_OUT_LSB    0
`define FFAM_MODE_PA_LSB     4
`define FFAM_MODE_PC_LSB     8
`define FFAM_MODE_MUX_LSB    12
`define FFAM_OUT_BAD_LO      4'h9
`define FFAM_PAIR_BAD_LO     4'h5
`define FFAM_PAIR_BAD_HI     4'h8
`define FFAM_DAC_LO          4'h1
`define FFAM_DAC_HI          4'h8
`define FFAM_DAC_BUFS        6'h03
`define FFAM_NUM_CHAN        3'h6

`endif

/* hw/ffam_pkg.sv */
// Types shared by the fault flag and alert mask block
package ffam_pkg;

   typedef logic [23:0] ffam_word_t;
   typedef logic [7:0]  ffam_addr_t;

   // Configuration holder state
   typedef struct packed {
      logic [5:0] buf_on;
      logic       ovc_mode;
      logic       crc_en;
      logic [3:0] out_mode;
      logic [3:0] pair_a;
      logic [3:0] pair_c;
      logic [2:0] mux_sel;
      logic       err_evt;
   } ffam_cfg_s;

   // Flag core state
   typedef struct packed {
      logic       ovc_meta;
      logic       ovc_sync;
      logic       ovc_flag;
      logic       cfg_sticky;
      logic       crc_flag;
      logic       edge_flag;
      ffam_word_t mask;
      ffam_word_t rdata;
      logic       alert_n;
   } ffam_core_s;

endpackage : ffam_pkg

/* hw/ffam_cfg_if.sv */
// Signals between the flag core and the configuration holder
`timescale 1ns/1ps
`default_nettype none

interface ffam_cfg_if;
   import ffam_pkg::*;

   logic       wr_gen;
   logic       wr_mode;
   ffam_word_t wdata;
   logic [5:0] buf_on;
   logic       ovc_mode;
   logic       crc_en;
   logic [3:0] out_mode;
   logic [3:0] pair_a;
   logic [3:0] pair_c;
   logic [2:0] mux_sel;
   logic       err_evt;
   logic       mux_bad;

   modport core (
      output wr_gen, wr_mode, wdata,
      input  buf_on, ovc_mode, crc_en, out_mode, pair_a, pair_c, mux_sel, err_evt, mux_bad
   );
   modport cfg (
      input  wr_gen, wr_mode, wdata,
      output buf_on, ovc_mode, crc_en, out_mode, pair_a, pair_c, mux_sel, err_evt, mux_bad
   );
endinterface : ffam_cfg_if

`default_nettype wire

/* hw/ffam_cfg.sv */
// Configuration holder: mode code checks and input buffer forcing
`timescale 1ns/1ps
`default_nettype none
`include "ffam_params.svh"

module ffam_cfg (
   input  wire logic   clk,
   input  wire logic   reset,
   ffam_cfg_if.cfg     cfg
);
   import ffam_pkg::*;

   ffam_cfg_s st_ff;
   ffam_cfg_s nxt_st;

   function automatic logic ffam_pair_bad(input logic [3:0] code);
      ffam_pair_bad = (code >= `FFAM_PAIR_BAD_LO) && (code <= `FFAM_PAIR_BAD_HI);
   endfunction : ffam_pair_bad

   function automatic logic [5:0] ffam_dac_bufs(input logic [3:0] code);
      ffam_dac_bufs = ((code >= `FFAM_DAC_LO) && (code <= `FFAM_DAC_HI)) ? `FFAM_DAC_BUFS : 6'h00;
   endfunction : ffam_dac_bufs

   always_comb begin
      logic [3:0] w_out;
      logic [3:0] w_pa;
      logic [3:0] w_pc;
      logic [5:0] need;
      w_out  = cfg.wdata[`FFAM_MODE_OUT_LSB +: 4];
      w_pa   = cfg.wdata[`FFAM_MODE_PA_LSB +: 4];
      w_pc   = cfg.wdata[`FFAM_MODE_PC_LSB +: 4];
      need   = 6'h00;
      nxt_st = st_ff;
      nxt_st.err_evt = 1'b0;
      if (cfg.wr_gen) begin
         nxt_st.buf_on   = cfg.wdata[`FFAM_GEN_BUF_LSB +: 6];
         nxt_st.ovc_mode = cfg.wdata[`FFAM_GEN_OVC_MODE];
         nxt_st.crc_en   = cfg.wdata[`FFAM_GEN_CRC_EN];
      end
      if (cfg.wr_mode) begin
         if (w_out >= `FFAM_OUT_BAD_LO) begin
            nxt_st.err_evt = 1'b1;
         end else begin
            nxt_st.out_mode = w_out;
            need            = ffam_dac_bufs(w_out);
         end
         if (ffam_pair_bad(w_pa)) begin
            nxt_st.err_evt = 1'b1;
         end else begin
            nxt_st.pair_a = w_pa;
         end
         if (ffam_pair_bad(w_pc)) begin
            nxt_st.err_evt = 1'b1;
         end else begin
            nxt_st.pair_c = w_pc;
         end
         nxt_st.mux_sel = cfg.wdata[`FFAM_MODE_MUX_LSB +: 3];
         if ((need & ~nxt_st.buf_on) != 6'h00) begin
            nxt_st.buf_on  = nxt_st.buf_on | need;
            nxt_st.err_evt = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign cfg.buf_on   = st_ff.buf_on;
   assign cfg.ovc_mode = st_ff.ovc_mode;
   assign cfg.crc_en   = st_ff.crc_en;
   assign cfg.out_mode = st_ff.out_mode;
   assign cfg.pair_a   = st_ff.pair_a;
   assign cfg.pair_c   = st_ff.pair_c;
   assign cfg.mux_sel  = st_ff.mux_sel;
   assign cfg.err_evt  = st_ff.err_evt;
   assign cfg.mux_bad  = (st_ff.mux_sel < `FFAM_NUM_CHAN) && !st_ff.buf_on[st_ff.mux_sel];

endmodule : ffam_cfg

`default_nettype wire

/* dv/ffam_core_monitor.sv */
// Port checker for the fault flag and alert mask block
`timescale 1ns/1ps
`default_nettype none
module ffam_core_monitor (
   input wire logic                 clk,
   input wire logic                 reset,
   input wire logic                 reg_wr,
   input wire logic                 reg_rd,
   input wire ffam_pkg::ffam_addr_t reg_addr,
   input wire ffam_pkg::ffam_word_t reg_wdata,
   input wire logic [23:0]          reg_rdata,
   input wire logic                 overcurrent_pin,
   input wire logic                 crc_mismatch,
   input wire logic [5:0]           gpi_edge,
   input wire logic                 alert_n
);
   import ffam_pkg::*;
   logic [3:0] msk_ff;
   logic       hmode_ff;
   logic       crc_ff;
   wire        st_rd = reg_rd && reg_addr == 8'h07;
   // Shadow copies, so alert checks know which flags may pull the pin
   always_ff @(posedge clk) begin
      if (reset) begin
         msk_ff <= 4'h0;
         hmode_ff <= 1'b0;
         crc_ff <= 1'b0;
      end else if (reg_wr && reg_addr == 8'h08) begin
         msk_ff <= reg_wdata[3:0];
      end else if (reg_wr && reg_addr == 8'h01) begin
         hmode_ff <= reg_wdata[6];
         crc_ff <= reg_wdata[7];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   mask_gate_a: assert property ($past(msk_ff) == 4'h0 && msk_ff == 4'h0 |-> alert_n)
      else $error("alert low with enables off");
   crc_alert_a: assert property (crc_mismatch && crc_ff && msk_ff[1] && !reg_wr
      |-> ##[1:2] !alert_n) else $error("crc error did not alert");
   edge_alert_a: assert property (|gpi_edge && msk_ff[0] && !reg_wr |-> ##[1:2] !alert_n)
      else $error("edge did not alert");
   ovc_alert_a: assert property ((overcurrent_pin && msk_ff[3] && !reg_wr)[*4] |=> !alert_n)
      else $error("overcurrent did not alert");
   ovc_auto_a: assert property (
      (!overcurrent_pin && !hmode_ff && msk_ff == 4'h8 && !reg_wr)[*5] |=> alert_n)
      else $error("auto clear failed");
   ovc_hold_a: assert property (
      hmode_ff && msk_ff == 4'h8 && !alert_n && !st_rd && !reg_wr |=> !alert_n)
      else $error("held overcurrent dropped");
   rd_clear_a: assert property (
      st_rd && msk_ff == 4'h2 && !crc_mismatch && !reg_wr |=> alert_n)
      else $error("read did not release alert");
   mask_rsvd_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'h08
      |-> reg_rdata[23:9] == 15'h0000 && !reg_rdata[5]) else $error("mask reserved bit set");
   cover property (st_rd && msk_ff != 4'h0);
   cover property (overcurrent_pin[*4]);
   cover property (crc_mismatch && crc_ff);
endmodule : ffam_core_monitor

bind ffam_core ffam_core_monitor ffam_core_monitor_inst (.clk(clk), .reset(reset),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .overcurrent_pin(overcurrent_pin), .crc_mismatch(crc_mismatch),
   .gpi_edge(gpi_edge), .alert_n(alert_n));
`default_nettype wire

/* dv/ffam_host.sv */
// Host model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module ffam_host (
   input  wire logic                clk,
   output var logic                 reg_wr,
   output var logic                 reg_rd,
   output var ffam_pkg::ffam_addr_t reg_addr,
   output var ffam_pkg::ffam_word_t reg_wdata,
   input  wire logic [23:0]         reg_rdata
);
   import ffam_pkg::*;
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 24'h000000;
   end
   // Released lines show inverted junk, not the last value
   task automatic wr(input ffam_addr_t a, input ffam_word_t v);
      @(negedge clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = v;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~v;
   endtask : wr
   task automatic rd(input ffam_addr_t a, output ffam_word_t v);
      @(negedge clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk);
      v = reg_rdata;
      reg_rd = 1'b0;
      reg_addr = ~a;
   endtask : rd
endmodule : ffam_host
`default_nettype wire

/* dv/tb.sv */
// Self-checking bench for the fault flag and alert mask block
`timescale 1ns/1ps
`default_nettype none
`include "ffam_params.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
   $display("FAIL %0t got %h exp %h", $time, g, e); end end
module tb;
   import ffam_pkg::*;
   logic       clk = 1'b0, reset = 1'b1, reg_wr, reg_rd, alert_n;
   logic       overcurrent_pin = 1'b0, crc_mismatch = 1'b0;
   logic [5:0] gpi_edge = 6'h00, buffer_power;
   logic [3:0] output_mode_code;
   ffam_addr_t reg_addr;
   ffam_word_t reg_wdata, d, w;
   logic [23:0] reg_rdata;
   int         i, bad_count = 0, cmp_count = 0;
   ffam_core ffam_core_inst (.clk(clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .overcurrent_pin(overcurrent_pin), .crc_mismatch(crc_mismatch), .gpi_edge(gpi_edge),
      .buffer_power(buffer_power), .output_mode_code(output_mode_code), .alert_n(alert_n));
   ffam_host ffam_host_inst (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   initial begin
      forever #5 clk = ~clk;
   end
   function automatic ffam_word_t mask_exp(input ffam_word_t v);
      return v & `FFAM_MASK_WMASK;
   endfunction : mask_exp
   task automatic pulse(input logic [6:0] p);
      @(negedge clk);
      crc_mismatch = p[6];
      gpi_edge = p[5:0];
      @(negedge clk);
      crc_mismatch = 1'b0;
      gpi_edge = 6'h00;
      @(negedge clk);
   endtask : pulse
   task automatic drive_pin(input logic v);
      @(negedge clk);
      overcurrent_pin = v;
      repeat (5) @(negedge clk);
   endtask : drive_pin
   task automatic stat(input ffam_word_t e);
      ffam_host_inst.rd(8'h07, d);
      `CHK(d, e)
   endtask : stat
   task automatic give_verdict;
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : give_verdict
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      give_verdict();
   end
   initial begin
      void'($urandom(32'hD88FED39));
      repeat (12) @(negedge clk);
      reset = 1'b0;
      ffam_host_inst.rd(8'h08, d);
      `CHK(d, 24'h000000)
      ffam_host_inst.wr(8'h01, 24'h00003F);
      stat(24'h000000);
      for (i = 0; i < 6; i++) begin
         w = (i == 0) ? 24'hFFFFFF : 24'($urandom);
         ffam_host_inst.wr(8'h08, w);
         ffam_host_inst.rd(8'h08, d);
         `CHK(d, mask_exp(w))
      end
      // Crc off first: a mismatch must leave no trace
      ffam_host_inst.wr(8'h08, 24'h000002);
      pulse(7'h40);
      `CHK(alert_n, 1'b1)
      stat(24'h000000);
      ffam_host_inst.wr(8'h01, 24'h0000BF);
      pulse(7'h40);
      `CHK(alert_n, 1'b0)
      stat(24'h000002);
      `CHK(alert_n, 1'b1)
      for (i = 0; i < 2; i++) begin
         ffam_host_inst.wr(8'h08, i ? 24'h000001 : 24'h000002);
         pulse({1'b0, 6'($urandom_range(63, 1))});
         `CHK(alert_n, i ? 1'b0 : 1'b1)
         stat(24'h000001);
         stat(24'h000000);
      end
      ffam_host_inst.wr(8'h08, 24'h000008);
      for (i = 0; i < 2; i++) begin
         ffam_host_inst.wr(8'h01, i ? 24'h0000FF : 24'h0000BF);
         drive_pin(1'b1);
         stat(24'h000008);
         drive_pin(1'b0);
         `CHK(alert_n, i ? 1'b0 : 1'b1)
         stat(i ? 24'h000008 : 24'h000000);
         stat(24'h000000);
      end
      ffam_host_inst.wr(8'h02, 24'h000003);
      for (i = 0; i < 11; i++) begin
         w = (i < 7) ? 24'(9 + i) : 24'h000003 | 24'((i - 2) << ($urandom_range(2, 1) * 4));
         ffam_host_inst.wr(8'h02, w);
         stat(24'h000004);
         `CHK(output_mode_code, 4'h3)
      end
      stat(24'h000000);
      // Dac mode with its buffers off
      ffam_host_inst.wr(8'h01, 24'h00003C);
      ffam_host_inst.wr(8'h02, 24'($urandom_range(8, 1)));
      repeat (2) @(negedge clk);
      stat(24'h000004);
      `CHK(buffer_power, 6'h3F)
      stat(24'h000000);
      ffam_host_inst.wr(8'h02, 24'h000000);
      ffam_host_inst.wr(8'h01, 24'h00003E);
      stat(24'h000004);
      stat(24'h000004);
      // Mux codes 6 and 7 select no channel
      ffam_host_inst.wr(8'h02, 24'h006000);
      stat(24'h000000);
      i = $urandom_range(5, 1);
      ffam_host_inst.wr(8'h02, 24'(i << 12));
      ffam_host_inst.wr(8'h01, 24'h00003F ^ 24'(1 << i));
      stat(24'h000004);
      ffam_host_inst.wr(8'h01, 24'h00003F);
      stat(24'h000000);
      give_verdict();
   end
endmodule : tb
`default_nettype wire
